// ==== logic/asfs_top.sv ====
// Converter scheduling, result registers and fault flags with an AXI4-Lite slave.
// Assumes synchronous pins, one clock, and aresetn driven by digital bias undervoltage.
`timescale 1ns/1ps
`include "asfs_defines.svh"
module asfs_top #(
  parameter int SLOT_CYC = `ASFS_SLOT_CYC
) (
  input  logic                        aclk,
  input  logic                        aresetn,
  input  logic                        ce,
  input  logic [7:0]                  s_axi_awaddr,
  input  logic                        s_axi_awvalid,
  output logic                        s_axi_awready,
  input  logic [31:0]                 s_axi_wdata,
  input  logic [3:0]                  s_axi_wstrb,
  input  logic                        s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  logic                        s_axi_bready,
  input  logic [7:0]                  s_axi_araddr,
  input  logic                        s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  logic                        s_axi_rready,
  output asfs_pkg::asfs_conv_req_type conv_req_q,
  input  asfs_pkg::asfs_conv_res_type conv_res,
  input  logic [1:0]                  pwm,
  input  logic [1:0]                  ch_run_req,
  input  logic [1:0]                  udim_uv,
  input  logic [1:0]                  switch_overtemp,
  input  logic [1:0]                  bst_uv,
  input  logic [1:0]                  comp_ov,
  input  logic                        analog_bias_uv,
  input  logic                        spi_error,
  input  logic                        watchdog_expire,
  output logic [1:0]                  ch_hs_en_q,
  output logic [1:0]                  ch_ls_on_q,
  output logic                        comp_discharge_q,
  output logic                        limp_mode_q,
  output logic [9:0]                  lh_reference_q
);
  asfs_pkg::asfs_src_type cur_sel_q;
  logic [7:0]  vin_q [2];
  logic [7:0]  vout_q [2];
  logic [7:0]  on_q [2];
  logic [7:0]  off_q [2];
  logic [7:0]  bias_q;
  logic [9:0]  temp_raw_q;
  logic [9:0]  temp_hold_q;
  logic [9:0]  thermal_warning_limit_q;
  logic        sleep_q;
  logic [1:0]  pwm_q;
  logic        pc_q;
  logic        abuv_q;
  logic [1:0]  wdto_q;
  logic [1:0]  s1_q;
  logic [3:0]  s2_q;
  logic [1:0]  s3_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  rd_off_q;
  logic        rd_done;
  logic        wr_go;
  logic        abuv_cond;
  logic        tw_cond;

  // Unmapped offsets answer SLVERR and read zero
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `ASFS_OFF_CTRL);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `ASFS_OFF_STAT1:  rd_mux = {30'h0, s1_q};
      `ASFS_OFF_STAT2:  rd_mux = {28'h0, s2_q};
      `ASFS_OFF_STAT3:  rd_mux = {26'h0, wdto_q, s3_q, abuv_q, pc_q};
      `ASFS_OFF_VIN1:   rd_mux = {24'h0, vin_q[0]};
      `ASFS_OFF_VIN2:   rd_mux = {24'h0, vin_q[1]};
      `ASFS_OFF_VOUT1:  rd_mux = {24'h0, vout_q[0]};
      `ASFS_OFF_VOUT2:  rd_mux = {24'h0, vout_q[1]};
      `ASFS_OFF_ON1:    rd_mux = {24'h0, on_q[0]};
      `ASFS_OFF_ON2:    rd_mux = {24'h0, on_q[1]};
      `ASFS_OFF_OFF1:   rd_mux = {24'h0, off_q[0]};
      `ASFS_OFF_OFF2:   rd_mux = {24'h0, off_q[1]};
      `ASFS_OFF_BIAS:   rd_mux = {24'h0, bias_q};
      `ASFS_OFF_LHLO:   rd_mux = {24'h0, lh_reference_q[7:0]};
      `ASFS_OFF_LHHI:   rd_mux = {30'h0, lh_reference_q[9:8]};
      `ASFS_OFF_TEMPLO: rd_mux = {24'h0, temp_raw_q[7:0]};
      `ASFS_OFF_TEMPHI: rd_mux = {30'h0, temp_hold_q[9:8]};
      `ASFS_OFF_CTRL:   rd_mux = {15'h0, sleep_q, 6'h0, thermal_warning_limit_q};
      default:          rd_mux = 32'h0000_0000;
    endcase
  endfunction

  asfs_sched #(
    .SLOT_CYC (SLOT_CYC),
    .SLOTS    (`ASFS_SLOTS)
  ) u_sched (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .req_q   (conv_req_q)
  );

  // Write side: address and data taken in either order, one write at a time
  assign wr_go   = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_done = s_axi_rvalid && s_axi_rready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ASFS_RESP_OKAY;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else if (ce) begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_q) ? `ASFS_RESP_OKAY : `ASFS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control word steers the warning compare and sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_warning_limit_q <= `ASFS_THERMAL_WARNING_LIMIT_RST;
      sleep_q <= 1'b0;
    end else if (ce && wr_go && awaddr_q == `ASFS_OFF_CTRL) begin
      if (wstrb_q[0]) thermal_warning_limit_q[7:0] <= wdata_q[7:0];
      if (wstrb_q[1]) thermal_warning_limit_q[9:8] <= wdata_q[9:8];
      if (wstrb_q[2]) sleep_q <= wdata_q[`ASFS_CTRL_SLEEP];
    end
  end

  // Read side: one read at a time, clear-on-read side effects bound to the response handshake, temperature hold to the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `ASFS_RESP_OKAY;
      rd_off_q      <= '0;
      temp_hold_q   <= '0;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux(s_axi_araddr);
        s_axi_rresp   <= mapped(s_axi_araddr) ? `ASFS_RESP_OKAY : `ASFS_RESP_SLVERR;
        rd_off_q      <= s_axi_araddr;
        if (s_axi_araddr == `ASFS_OFF_TEMPLO) temp_hold_q <= temp_raw_q;
      end else if (rd_done) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Conversion results land by the source of the slot that issued them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_sel_q      <= asfs_pkg::SRC_VIN1;
      vin_q          <= '{default: 8'h00};
      vout_q         <= '{default: 8'h00};
      bias_q         <= '0;
      lh_reference_q <= '0;
      temp_raw_q     <= '0;
    end else if (ce) begin
      if (conv_req_q.start) cur_sel_q <= conv_req_q.sel;
      if (conv_res.valid) begin
        case (cur_sel_q)
          asfs_pkg::SRC_VIN1:   vin_q[0] <= conv_res.data[9:2];
          asfs_pkg::SRC_VIN2:   vin_q[1] <= conv_res.data[9:2];
          asfs_pkg::SRC_SENSE1: vout_q[0] <= conv_res.data[9:2];
          asfs_pkg::SRC_SENSE2: vout_q[1] <= conv_res.data[9:2];
          asfs_pkg::SRC_BIAS:   bias_q <= conv_res.data[9:2];
          asfs_pkg::SRC_LIMP:   lh_reference_q <= conv_res.data;
          asfs_pkg::SRC_TEMP:   temp_raw_q <= conv_res.data;
          default:              bias_q <= bias_q;
        endcase
      end
    end
  end

  // Snapshots taken at PWM edges since sampling is not tied to the PWM phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_q <= '0;
      on_q  <= '{default: 8'h00};
      off_q <= '{default: 8'h00};
    end else if (ce) begin
      pwm_q <= pwm;
      for (int i = 0; i < 2; i++) begin
        if (pwm_q[i] && !pwm[i]) on_q[i] <= vout_q[i];
        if (!pwm_q[i] && pwm[i]) off_q[i] <= vout_q[i];
      end
    end
  end

  assign abuv_cond = analog_bias_uv || sleep_q;
  assign tw_cond   = temp_raw_q[9:2] > thermal_warning_limit_q[9:2];

  // Reset stands for digital bias undervoltage, hence the power-cycle flag resets high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q        <= 1'b1;
      abuv_q      <= 1'b0;
      wdto_q      <= '0;
      limp_mode_q <= 1'b0;
    end else if (ce) begin
      if (rd_done && rd_off_q == `ASFS_OFF_STAT3) pc_q <= 1'b0;
      abuv_q <= abuv_cond;
      if (watchdog_expire) begin
        limp_mode_q <= 1'b1;
        if (wdto_q != 2'h3) wdto_q <= wdto_q + 2'h1;
      end
    end
  end

  asfs_flags #(
    .W (2)
  ) u_stat1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .cond    (comp_ov),
    .rd_clr  (rd_done && rd_off_q == `ASFS_OFF_STAT1),
    .flags_q (s1_q)
  );

  asfs_flags #(
    .W (4)
  ) u_stat2 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .cond    ({bst_uv, switch_overtemp}),
    .rd_clr  (rd_done && rd_off_q == `ASFS_OFF_STAT2),
    .flags_q (s2_q)
  );

  asfs_flags #(
    .W (2)
  ) u_stat3 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .cond    ({spi_error, tw_cond}),
    .rd_clr  (rd_done && rd_off_q == `ASFS_OFF_STAT3),
    .flags_q (s3_q)
  );

  // Switch control; compensation overvoltage deliberately has no effect here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch_hs_en_q       <= '0;
      ch_ls_on_q       <= '0;
      comp_discharge_q <= 1'b0;
    end else if (ce) begin
      comp_discharge_q <= abuv_cond;
      for (int i = 0; i < 2; i++) begin
        ch_hs_en_q[i] <= ch_run_req[i] && !udim_uv[i] && !switch_overtemp[i]
                         && !bst_uv[i] && !abuv_cond;
        ch_ls_on_q[i] <= bst_uv[i] && ch_run_req[i] && !switch_overtemp[i] && !abuv_cond;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pc_after_reset_a: assert property (aresetn && $past(!aresetn) |-> pc_q)
    else $error("power-cycle flag low after reset");
  pc_read_clear_a: assert property (ce && rd_done && rd_off_q == `ASFS_OFF_STAT3 |=> !pc_q)
    else $error("power-cycle flag kept after status read");
  abuv_sleep_a: assert property (ce && sleep_q |=> abuv_q && comp_discharge_q && ch_hs_en_q == 2'h0)
    else $error("sleep did not raise analog bias flag");
  vin_msb_a: assert property (ce && conv_res.valid && cur_sel_q == asfs_pkg::SRC_VIN1
    |=> vin_q[0] == $past(conv_res.data[9:2]))
    else $error("input voltage not upper bits");
  vout_update_a: assert property (ce && conv_res.valid && cur_sel_q == asfs_pkg::SRC_SENSE2
    |=> vout_q[1] == $past(conv_res.data[9:2]))
    else $error("output voltage not updated");
  on_snapshot_a: assert property (ce && pwm_q[0] && !pwm[0] |=> on_q[0] == $past(vout_q[0]))
    else $error("on snapshot missed falling edge");
  off_snapshot_a: assert property (ce && !pwm_q[1] && pwm[1] |=> off_q[1] == $past(vout_q[1]))
    else $error("off snapshot missed rising edge");
  temp_hold_a: assert property (!(s_axi_arvalid && s_axi_arready && s_axi_araddr == `ASFS_OFF_TEMPLO)
    |=> $stable(temp_hold_q))
    else $error("temperature pair refreshed without low read");
  warn_set_a: assert property (ce && tw_cond ##1 ce |=> s3_q[0])
    else $error("thermal warning not set");
  thermal_off_a: assert property (ce && switch_overtemp[1] |=> !ch_hs_en_q[1] && s2_q[1])
    else $error("overtemperature did not shut channel");
  uvlo_one_ch_a: assert property (ce && udim_uv[0] |=> !ch_hs_en_q[0])
    else $error("input undervoltage left switching on");
  bootstrap_a: assert property (ce && bst_uv[0] && ch_run_req[0] && !switch_overtemp[0] && !abuv_cond
    |=> !ch_hs_en_q[0] && ch_ls_on_q[0] && s2_q[`ASFS_S2_BSTUV])
    else $error("bootstrap undervoltage handling wrong");
  wdto_count_a: assert property (ce && watchdog_expire && wdto_q == 2'h1 |=> wdto_q == 2'h2 && limp_mode_q)
    else $error("watchdog timeout not counted");

  pc_cleared_c: cover property (pc_q ##1 !pc_q);
  snapshot_c:   cover property (ce && pwm_q[0] && !pwm[0]);
  temp_read_c:  cover property (rd_done && rd_off_q == `ASFS_OFF_TEMPLO ##[1:20] rd_done && rd_off_q == `ASFS_OFF_TEMPHI);
  write_c:      cover property (s_axi_bvalid && s_axi_bready);
endmodule

// ==== inc/asfs_defines.svh ====
// Offsets, reset values and timing counts of the housekeeping block.
// Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock.
`ifndef ASFS_DEFINES_SVH
`define ASFS_DEFINES_SVH
`define ASFS_CLK_MHZ        50
`define ASFS_SLOT_NS        18000
`define ASFS_SLOT_CYC       ((`ASFS_SLOT_NS * `ASFS_CLK_MHZ + 999) / 1000)
`define ASFS_SLOTS          45
`define ASFS_GROUP          9
`define ASFS_OFF_STAT1      8'h00
`define ASFS_OFF_STAT2      8'h04
`define ASFS_OFF_STAT3      8'h08
`define ASFS_OFF_VIN1       8'h0c
`define ASFS_OFF_VIN2       8'h10
`define ASFS_OFF_VOUT1      8'h14
`define ASFS_OFF_VOUT2      8'h18
`define ASFS_OFF_ON1        8'h1c
`define ASFS_OFF_ON2        8'h20
`define ASFS_OFF_OFF1       8'h24
`define ASFS_OFF_OFF2       8'h28
`define ASFS_OFF_BIAS       8'h2c
`define ASFS_OFF_LHLO       8'h30
`define ASFS_OFF_LHHI       8'h34
`define ASFS_OFF_TEMPLO     8'h38
`define ASFS_OFF_TEMPHI     8'h3c
`define ASFS_OFF_CTRL       8'h40
`define ASFS_CTRL_SLEEP     16
`define ASFS_S3_PC          0
`define ASFS_S3_ABUV        1
`define ASFS_S3_TW          2
`define ASFS_S3_SERR        3
`define ASFS_S3_WDTO        4
`define ASFS_S2_BSTUV       2
`define ASFS_THERMAL_WARNING_LIMIT_RST      10'h3ff
`define ASFS_RESP_OKAY      2'h0
`define ASFS_RESP_SLVERR    2'h2
`endif

// ==== inc/asfs_pkg.sv ====
// Types shared by the housekeeping block.
// Assumes the defines header for all numeric values.
package asfs_pkg;
  typedef enum logic [2:0] {
    SRC_VIN1,
    SRC_VIN2,
    SRC_SENSE1,
    SRC_SENSE2,
    SRC_BIAS,
    SRC_LIMP,
    SRC_TEMP
  } asfs_src_type;

  typedef struct packed {
    logic         start;
    asfs_src_type sel;
  } asfs_conv_req_type;

  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } asfs_conv_res_type;
endpackage

// ==== logic/asfs_flags.sv ====
// Sticky fault flags that clear on a status read when their cause is gone.
// Assumes rd_clr pulses once at the end of the read response.
`timescale 1ns/1ps
module asfs_flags #(
  parameter int W = 2
) (
  input  logic         aclk,
  input  logic         aresetn,
  input  logic         ce,
  input  logic [W-1:0] cond,
  input  logic         rd_clr,
  output logic [W-1:0] flags_q
);
  if (W < 1) begin : g_bad_w
    $error("asfs_flags: W must be at least 1");
  end

  // A live cause keeps its bit, so a set in the clearing cycle is never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
    end else if (ce) begin
      flags_q <= cond | (flags_q & {W{~rd_clr}});
    end
  end

  rd_clear_gone_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && rd_clr && cond == '0 |=> flags_q == '0)
    else $error("flag survived a clearing read");
endmodule

// ==== logic/asfs_sched.sv ====
// Round-robin slot scheduler of the shared converter.
// Assumes the converter finishes each conversion within one slot.
`timescale 1ns/1ps
`include "asfs_defines.svh"
module asfs_sched #(
  parameter int SLOT_CYC = `ASFS_SLOT_CYC,
  parameter int SLOTS    = `ASFS_SLOTS
) (
  input  logic                       aclk,
  input  logic                       aresetn,
  input  logic                       ce,
  output asfs_pkg::asfs_conv_req_type req_q
);
  logic [11:0] cnt_q;
  logic [5:0]  idx_q;
  logic [5:0]  idx_d;

  if (SLOT_CYC < 2 || SLOT_CYC > 4095 || SLOTS != 5 * `ASFS_GROUP) begin : g_bad_slot
    $error("asfs_sched: bad slot parameters");
  end

  // One other input in fixed order, then eight sense samples
  function automatic asfs_pkg::asfs_src_type src_of(input logic [5:0] idx);
    logic [5:0] pos;
    logic [5:0] grp;
    pos = idx % 6'(`ASFS_GROUP);
    grp = idx / 6'(`ASFS_GROUP);
    if (pos != 6'h00) begin
      src_of = pos[0] ? asfs_pkg::SRC_SENSE1 : asfs_pkg::SRC_SENSE2;
    end else begin
      case (grp)
        6'h00:   src_of = asfs_pkg::SRC_VIN1;
        6'h01:   src_of = asfs_pkg::SRC_BIAS;
        6'h02:   src_of = asfs_pkg::SRC_VIN2;
        6'h03:   src_of = asfs_pkg::SRC_LIMP;
        default: src_of = asfs_pkg::SRC_TEMP;
      endcase
    end
  endfunction

  assign idx_d = (idx_q == 6'(SLOTS - 1)) ? 6'h00 : idx_q + 6'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      idx_q <= 6'(SLOTS - 1);
      req_q <= '{start: 1'b0, sel: asfs_pkg::SRC_VIN1};
    end else if (ce) begin
      req_q.start <= 1'b0;
      if (cnt_q == 12'(SLOT_CYC - 1)) begin
        cnt_q     <= '0;
        idx_q     <= idx_d;
        req_q.start <= 1'b1;
        req_q.sel <= src_of(idx_d);
      end else begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end

  vin1_every_45_a: assert property (@(posedge aclk) disable iff (!aresetn)
    req_q.start && req_q.sel == asfs_pkg::SRC_VIN1 |-> idx_q == 6'h00)
    else $error("first input visited out of place");
  slot_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cnt_q == 12'(SLOT_CYC - 1) |=> req_q.start)
    else $error("slot did not start on time");
  sense_slot_a: assert property (@(posedge aclk) disable iff (!aresetn)
    req_q.start && idx_q % 6'(`ASFS_GROUP) != 6'h00 |->
      (req_q.sel == asfs_pkg::SRC_SENSE1 || req_q.sel == asfs_pkg::SRC_SENSE2))
    else $error("non-sense input inside a sense run");
  temp_slot_c: cover property (@(posedge aclk) req_q.start && req_q.sel == asfs_pkg::SRC_TEMP);
endmodule

// ==== dv/asfs_adc_model.sv ====
// Converter model: answers each slot start with a result tagged by its source.
// Assumes the scheduler leaves at least DLY+1 cycles between slot starts.
`timescale 1ns/1ps
module asfs_adc_model #(
  parameter int DLY = 1
) (
  input  wire asfs_pkg::asfs_conv_req_type req,
  input  wire logic                        aclk,
  output asfs_pkg::asfs_conv_res_type      res
);
  int         cnt = 0;
  logic [2:0] src = 3'h0;
  initial res = '0;
  // Idle data toggles so a stale result never passes for a fresh one
  always @(posedge aclk) begin
    res.valid <= 1'b0;
    res.data  <= ~res.data;
    if (req.start === 1'b1) begin
      cnt <= DLY;
      src <= req.sel;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        res.valid <= 1'b1;
        res.data  <= {src, 7'h35};
      end
    end
  end
endmodule

// ==== dv/asfs_top_tb.sv ====
// Bench of the housekeeping block: AXI4-Lite master tasks and scenarios.
// Assumes the converter model and a shortened slot length.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
`define WT(c) begin n = 0; do begin @(posedge aclk); n++; end while (!(c) && n < 100); \
  if (!(c)) begin err_total++; summarize(); end end
module asfs_top_tb;
  localparam int SLOT = 4;
  logic                        aclk = 0, aresetn = 0, ce = 1;
  logic [7:0]                  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0]                 s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0]                  s_axi_wstrb = 0;
  logic                        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic                        s_axi_arvalid = 0, s_axi_rready = 0;
  logic                        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]                  s_axi_bresp, s_axi_rresp, rp;
  asfs_pkg::asfs_conv_req_type conv_req_q;
  asfs_pkg::asfs_conv_res_type conv_res;
  logic [1:0]                  pwm = 0, ch_run_req = 0, udim_uv = 0, switch_overtemp = 0, bst_uv = 0, comp_ov = 0;
  logic                        analog_bias_uv = 0, spi_error = 0, watchdog_expire = 0;
  logic [1:0]                  ch_hs_en_q, ch_ls_on_q;
  logic                        comp_discharge_q, limp_mode_q;
  logic [9:0]                  lh_reference_q;
  int                          err_total = 0, comparisons = 0, n;

  always #10 aclk = ~aclk;

  asfs_top #(.SLOT_CYC(SLOT)) u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .conv_req_q, .conv_res, .pwm, .ch_run_req, .udim_uv, .switch_overtemp, .bst_uv, .comp_ov, .analog_bias_uv,
    .spi_error, .watchdog_expire, .ch_hs_en_q, .ch_ls_on_q, .comp_discharge_q, .limp_mode_q, .lh_reference_q);
  asfs_adc_model #(.DLY(1)) u_adc (.aclk(aclk), .req(conv_req_q), .res(conv_res));

  function automatic logic [31:0] ex(int s, int sh);
    return 32'({s[2:0], 7'h35}) >> sh;
  endfunction

  task automatic summarize();
    $display("counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    `WT(s_axi_arready === 1'b1)
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    `WT(s_axi_rvalid === 1'b1)
    d = s_axi_rdata;
    rp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rr(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ka, kw;
    ka = 0;
    kw = 0;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    // Either channel may be taken first; each is released on its own
    do begin
      @(posedge aclk);
      n++;
      ka |= (s_axi_awready === 1'b1);
      kw |= (s_axi_wready === 1'b1);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
    end while (!(ka && kw) && n < 100);
    s_axi_bready <= 1'b1;
    `WT(s_axi_bvalid === 1'b1)
    rp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic t_sched();
    asfs_pkg::asfs_src_type oth[5] = '{asfs_pkg::SRC_VIN1, asfs_pkg::SRC_BIAS, asfs_pkg::SRC_VIN2,
                                       asfs_pkg::SRC_LIMP, asfs_pkg::SRC_TEMP};
    time tp;
    tp = 0;
    for (int i = 0; i <= 45; i++) begin
      `WT(conv_req_q.start === 1'b1)
      if (i % 9 == 0) `CHK(conv_req_q.sel, oth[(i / 9) % 5])
      else `CHK(conv_req_q.sel, ((i % 9) % 2) ? asfs_pkg::SRC_SENSE1 : asfs_pkg::SRC_SENSE2)
      if (i > 0) `CHK(($time - tp) / 20, SLOT)
      tp = $time;
    end
    $display("test sched finished");
  endtask

  task automatic t_res();
    logic [7:0] ad[5] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h2c};
    for (int i = 0; i < 5; i++) rr(ad[i], ex(i, 2));
    rr(8'h30, ex(5, 0) & 32'hff);
    rr(8'h34, ex(5, 8));
    `CHK(lh_reference_q, 10'(ex(5, 0)))
    rr(8'h3c, 32'h0);
    rr(8'h38, ex(6, 0) & 32'hff);
    rr(8'h3c, ex(6, 8));
    pwm <= 2'b11;
    cyc(3);
    rr(8'h1c, 32'h0);
    rr(8'h24, ex(2, 2));
    pwm <= 2'b00;
    cyc(3);
    rr(8'h20, ex(3, 2));
    rr(8'h28, ex(3, 2));
    $display("test results finished");
  endtask

  task automatic t_stat3();
    rr(8'h08, 32'h1);
    rr(8'h08, 32'h0);
    wr(8'h40, 32'h0, 4'h3);
    `CHK(rp, 2'h0)
    cyc(4);
    rr(8'h08, 32'h4);
    spi_error       <= 1'b1;
    watchdog_expire <= 1'b1;
    cyc(1);
    spi_error       <= 1'b0;
    watchdog_expire <= 1'b0;
    cyc(1);
    watchdog_expire <= 1'b1;
    cyc(1);
    watchdog_expire <= 1'b0;
    cyc(3);
    rr(8'h08, 32'h2c);
    `CHK(limp_mode_q, 1'b1)
    rd(8'h44);
    `CHK({rp, d}, {2'h2, 32'h0})
    wr(8'h44, 32'h0, 4'hf);
    `CHK(rp, 2'h2)
    $display("test third_status_register finished");
  endtask

  task automatic t_fault();
    // Power-cycle flag is already cleared here, before channels run
    ch_run_req <= 2'b11;
    udim_uv    <= 2'b01;
    cyc(3);
    `CHK(ch_hs_en_q, 2'b10)
    udim_uv         <= 2'b00;
    switch_overtemp <= 2'b10;
    cyc(3);
    `CHK(ch_hs_en_q, 2'b01)
    rr(8'h04, 32'h2);
    switch_overtemp <= 2'b00;
    bst_uv          <= 2'b01;
    comp_ov         <= 2'b11;
    cyc(3);
    `CHK({ch_hs_en_q, ch_ls_on_q}, 4'b1001)
    rr(8'h04, 32'h6);
    rr(8'h04, 32'h4);
    rr(8'h00, 32'h3);
    bst_uv         <= 2'b00;
    analog_bias_uv <= 1'b1;
    cyc(3);
    `CHK({ch_hs_en_q, comp_discharge_q}, 3'b001)
    analog_bias_uv <= 1'b0;
    wr(8'h40, 32'h10000, 4'h4);
    cyc(3);
    rd(8'h08);
    `CHK({d[1], ch_hs_en_q, comp_discharge_q}, 4'b1001)
    wr(8'h40, 32'h0, 4'h4);
    cyc(3);
    rd(8'h08);
    `CHK({d[1], ch_hs_en_q, comp_discharge_q}, 4'b0110)
    // Clock enable low must hold every output where it stands
    ce      <= 1'b0;
    udim_uv <= 2'b11;
    cyc(3);
    `CHK(ch_hs_en_q, 2'b11)
    ce <= 1'b1;
    cyc(3);
    `CHK(ch_hs_en_q, 2'b00)
    udim_uv <= 2'b00;
    $display("test faults finished");
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_sched();
    t_res();
    t_stat3();
    t_fault();
    summarize();
  end
endmodule
